// ### hw/byte_reg.v
/*
 * One byte-wide software register with a synchronous reset value and a
 * write mask; masked-off bits hold zero.
 * Assumes one clock; writes come from the control port decode.
 */
`timescale 1ns/1ps

module byte_reg #(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] WRITE_MASK  = 8'hFF
) (
    input  wire       sys_clk_i,
    input  wire       reset_i,
    input  wire       write_i,
    input  wire [7:0] data_i,
    output wire [7:0] value_o
);

    reg [7:0] value_reg;

    always @(posedge sys_clk_i)
    begin
        if (reset_i)
            value_reg <= RESET_VALUE & WRITE_MASK;
        else if (write_i)
            value_reg <= data_i & WRITE_MASK;
    end

    assign value_o = value_reg;

endmodule // byte_reg

// ### hw/synth_fraction_phase_map.vh
/*
 * Address map, field positions and reset values of the fraction, modulus,
 * phase offset and pump current register slice.
 * Assumes byte-wide registers reached over the serial control port.
 */
`ifndef SYNTH_FRACTION_PHASE_MAP_VH
`define SYNTH_FRACTION_PHASE_MAP_VH

`define ADDR_INTEGER_LOW          8'h10
`define ADDR_FRACTION_PRIMARY_TOP 8'h16
`define ADDR_FRACTION_MIXED_LOW   8'h17
`define ADDR_FRACTION_AUX_HIGH    8'h18
`define ADDR_MODULUS_AUX_LOW      8'h19
`define ADDR_MODULUS_HIGH_PHASE   8'h1A
`define ADDR_PHASE_OFFSET_LOW     8'h1B
`define ADDR_PHASE_OFFSET_MID     8'h1C
`define ADDR_PHASE_OFFSET_HIGH    8'h1D
`define ADDR_PUMP_CURRENT_CTRL    8'h1E

`define RST_FRACTION_PRIMARY_TOP  8'h00
`define RST_FRACTION_MIXED_LOW    8'h00
`define RST_FRACTION_AUX_HIGH     7'h00
`define RST_MODULUS_AUX_LOW       8'hE8
`define RST_MODULUS_HIGH          6'h03
`define RST_PHASE_SHIFT_ENABLE    1'h0
`define RST_PHASE_OFFSET          24'h000000
`define RST_PHASE_OFFSET_BYTE     8'h00
`define RST_AUX_FRACTION          14'h0000
`define RST_PUMP_CURRENT_CTRL     8'h48
`define RST_PUMP_CURRENT_CODE     4'h4
`define RST_PUMP_CONFIG_LOW       4'h8

`define MASK_RESERVED_TOP         8'h7F

`define POS_PHASE_SHIFT_ENABLE    6
`define POS_PUMP_CURRENT_LSB      4
`define POS_PUMP_CURRENT_MSB      7
`define POS_PUMP_CONFIG_MSB       3
`define POS_PRIMARY_FRACTION_BIT24 0
`define POS_AUX_FRACTION_LOW_MSB  7
`define POS_AUX_FRACTION_LOW_LSB  1
`define POS_AUX_FRACTION_HIGH_MSB 6
`define POS_MODULUS_HIGH_MSB      5

`endif

// ### hw/synth_fraction_phase_regs.v
/*
 * Register slice for the fractional divider words, phase offset and pump
 * current, with double buffering of the divider words.
 * Assumes the serial control port delivers one-cycle byte write strobes
 * and byte read addresses on sys_clk_i.
 */
`timescale 1ns/1ps
`include "synth_fraction_phase_map.vh"

// Behaviour
// - Primary fraction bits 24:16 in 0x16, 0x17.
// - Auxiliary fraction split across 0x17 and 0x18.
// - Auxiliary modulus in 0x19, 0x1A, reset 0x3E8.
// - Phase shift enable at 0x1A bit 6.
// - Phase shift is relative advance, not absolute.
// - Phase offset word spans 0x1B to 0x1D.
// - Pump current code at 0x1E bits 7:4.
// - Register 0x1E resets to 0x48 whole.
// - Divider words apply on integer low write.
module synth_fraction_phase_regs (
    input  wire        sys_clk_i,
    input  wire        reset_i,
    input  wire        wr_strobe_i,
    input  wire [7:0]  wr_addr_i,
    input  wire [7:0]  wr_data_i,
    input  wire [7:0]  rd_addr_i,
    output reg  [7:0]  rd_data_o,
    output reg         rd_hit_o,
    output reg  [8:0]  primary_fraction_top_o,
    output reg  [13:0] auxiliary_fraction_word_o,
    output reg  [13:0] auxiliary_modulus_word_o,
    output reg         phase_shift_enable_o,
    output reg  [23:0] phase_offset_word_o,
    output reg         phase_advance_pulse_o,
    output reg  [3:0]  pump_current_code_o,
    output reg  [3:0]  pump_config_low_o
);

    wire [7:0] fraction_primary_top;
    wire [7:0] fraction_mixed_low;
    wire [7:0] fraction_aux_high;
    wire [7:0] modulus_aux_low;
    wire [7:0] modulus_high_phase_ctrl;
    wire [7:0] phase_offset_low;
    wire [7:0] phase_offset_mid;
    wire [7:0] phase_offset_high;
    wire [7:0] pump_current_ctrl;
    reg  [7:0] rd_data_next;
    reg        rd_hit_next;

    // One strobe per cycle, so at most one register decodes a hit.
    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = wr_strobe_i && (wr_addr_i == addr);
        end
    endfunction

    byte_reg #(.RESET_VALUE(`RST_FRACTION_PRIMARY_TOP), .WRITE_MASK(8'hFF)) u_frac_top (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_FRACTION_PRIMARY_TOP)),
        .data_i    (wr_data_i),
        .value_o   (fraction_primary_top)
    );

    byte_reg #(.RESET_VALUE(`RST_FRACTION_MIXED_LOW), .WRITE_MASK(8'hFF)) u_frac_mixed (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_FRACTION_MIXED_LOW)),
        .data_i    (wr_data_i),
        .value_o   (fraction_mixed_low)
    );

    // Bit 7 is reserved: the mask keeps it at zero whatever software writes.
    byte_reg #(
        .RESET_VALUE({1'b0, `RST_FRACTION_AUX_HIGH}),
        .WRITE_MASK (`MASK_RESERVED_TOP)
    ) u_aux_high (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_FRACTION_AUX_HIGH)),
        .data_i    (wr_data_i),
        .value_o   (fraction_aux_high)
    );

    byte_reg #(.RESET_VALUE(`RST_MODULUS_AUX_LOW), .WRITE_MASK(8'hFF)) u_mod_low (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_MODULUS_AUX_LOW)),
        .data_i    (wr_data_i),
        .value_o   (modulus_aux_low)
    );

    // Bit 7 is masked off so it holds zero; bit 6 is the enable.
    byte_reg #(
        .RESET_VALUE({1'b0, `RST_PHASE_SHIFT_ENABLE, `RST_MODULUS_HIGH}),
        .WRITE_MASK (`MASK_RESERVED_TOP)
    ) u_mod_high (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_MODULUS_HIGH_PHASE)),
        .data_i    (wr_data_i),
        .value_o   (modulus_high_phase_ctrl)
    );

    // The offset bytes are not double buffered; each one reaches
    // phase_offset_word_o one cycle after it is written.
    byte_reg #(.RESET_VALUE(`RST_PHASE_OFFSET_BYTE), .WRITE_MASK(8'hFF)) u_phase_low (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_PHASE_OFFSET_LOW)),
        .data_i    (wr_data_i),
        .value_o   (phase_offset_low)
    );

    byte_reg #(.RESET_VALUE(`RST_PHASE_OFFSET_BYTE), .WRITE_MASK(8'hFF)) u_phase_mid (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_PHASE_OFFSET_MID)),
        .data_i    (wr_data_i),
        .value_o   (phase_offset_mid)
    );

    byte_reg #(.RESET_VALUE(`RST_PHASE_OFFSET_BYTE), .WRITE_MASK(8'hFF)) u_phase_high (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_PHASE_OFFSET_HIGH)),
        .data_i    (wr_data_i),
        .value_o   (phase_offset_high)
    );

    byte_reg #(.RESET_VALUE(`RST_PUMP_CURRENT_CTRL), .WRITE_MASK(8'hFF)) u_pump (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .write_i   (wr_hit(`ADDR_PUMP_CURRENT_CTRL)),
        .data_i    (wr_data_i),
        .value_o   (pump_current_ctrl)
    );

    // Divider words are shadowed so a multi-byte update never reaches the
    // divider half written; only the integer low byte write commits them.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            primary_fraction_top_o    <= {1'b0, `RST_FRACTION_PRIMARY_TOP};
            auxiliary_fraction_word_o <= `RST_AUX_FRACTION;
            auxiliary_modulus_word_o  <= {`RST_MODULUS_HIGH, `RST_MODULUS_AUX_LOW};
        end
        else if (wr_hit(`ADDR_INTEGER_LOW))
        begin
            primary_fraction_top_o    <= {fraction_mixed_low[`POS_PRIMARY_FRACTION_BIT24],
                                          fraction_primary_top};
            auxiliary_fraction_word_o <= {fraction_aux_high[`POS_AUX_FRACTION_HIGH_MSB:0],
                                          fraction_mixed_low[`POS_AUX_FRACTION_LOW_MSB:
                                                             `POS_AUX_FRACTION_LOW_LSB]};
            auxiliary_modulus_word_o  <= {modulus_high_phase_ctrl[`POS_MODULUS_HIGH_MSB:0],
                                          modulus_aux_low};
        end
    end

    // A phase shift is a relative advance: one pulse is issued each time the
    // top offset byte is written while enabled, so the loop adds the offset
    // to its present phase instead of loading it.
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            phase_shift_enable_o  <= `RST_PHASE_SHIFT_ENABLE;
            phase_offset_word_o   <= `RST_PHASE_OFFSET;
            phase_advance_pulse_o <= 1'b0;
            pump_current_code_o   <= `RST_PUMP_CURRENT_CODE;
            pump_config_low_o     <= `RST_PUMP_CONFIG_LOW;
        end
        else
        begin
            phase_shift_enable_o  <= modulus_high_phase_ctrl[`POS_PHASE_SHIFT_ENABLE];
            phase_offset_word_o   <= {phase_offset_high, phase_offset_mid,
                                      phase_offset_low};
            phase_advance_pulse_o <= modulus_high_phase_ctrl[`POS_PHASE_SHIFT_ENABLE]
                                     && wr_hit(`ADDR_PHASE_OFFSET_HIGH);
            pump_current_code_o   <= pump_current_ctrl[`POS_PUMP_CURRENT_MSB:
                                                       `POS_PUMP_CURRENT_LSB];
            pump_config_low_o     <= pump_current_ctrl[`POS_PUMP_CONFIG_MSB:0];
        end
    end

    // Reads are registered so rd_data_o comes straight from a flop; the
    // value shown belongs to the address presented one cycle earlier.
    always @*
    begin
        rd_hit_next  = 1'b1;
        rd_data_next = 8'h00;
        case (rd_addr_i)
            `ADDR_FRACTION_PRIMARY_TOP: rd_data_next = fraction_primary_top;
            `ADDR_FRACTION_MIXED_LOW:   rd_data_next = fraction_mixed_low;
            `ADDR_FRACTION_AUX_HIGH:    rd_data_next = fraction_aux_high;
            `ADDR_MODULUS_AUX_LOW:      rd_data_next = modulus_aux_low;
            `ADDR_MODULUS_HIGH_PHASE:   rd_data_next = modulus_high_phase_ctrl;
            `ADDR_PHASE_OFFSET_LOW:     rd_data_next = phase_offset_low;
            `ADDR_PHASE_OFFSET_MID:     rd_data_next = phase_offset_mid;
            `ADDR_PHASE_OFFSET_HIGH:    rd_data_next = phase_offset_high;
            `ADDR_PUMP_CURRENT_CTRL:    rd_data_next = pump_current_ctrl;
            default:                    rd_hit_next  = 1'b0;
        endcase
    end

    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rd_data_o <= 8'h00;
            rd_hit_o  <= 1'b0;
        end
        else
        begin
            rd_data_o <= rd_data_next;
            rd_hit_o  <= rd_hit_next;
        end
    end

endmodule // synth_fraction_phase_regs

// ### sim/synth_fraction_phase_regs_chk.sv
/* Concurrent checks on the ports of the fraction and phase register slice.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module synth_fraction_phase_regs_chk (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic        wr_strobe_i,
    input wire logic [7:0]  wr_addr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic [7:0]  rd_addr_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        rd_hit_o,
    input wire logic [8:0]  primary_fraction_top_o,
    input wire logic [13:0] auxiliary_fraction_word_o,
    input wire logic [13:0] auxiliary_modulus_word_o,
    input wire logic        phase_shift_enable_o,
    input wire logic [23:0] phase_offset_word_o,
    input wire logic        phase_advance_pulse_o,
    input wire logic [3:0]  pump_current_code_o,
    input wire logic [3:0]  pump_config_low_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // The first edge after reset compares against reset-time values, so it is skipped.
    property p_hold;
        !$past(reset_i) && !($past(wr_strobe_i) && $past(wr_addr_i) == 8'h10)
        |-> $stable(auxiliary_modulus_word_o) && $stable(primary_fraction_top_o)
            && $stable(auxiliary_fraction_word_o);
    endproperty
    a_hold: assert property (p_hold) else $error("divider word moved without commit");
    property p_resv;
        !$past(reset_i) && ($past(rd_addr_i) == 8'h18 || $past(rd_addr_i) == 8'h1A)
        |-> !rd_data_o[7];
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit read as one");
    property p_en;
        wr_strobe_i && wr_addr_i == 8'h1A
        |-> ##2 phase_shift_enable_o == $past(wr_data_i[6], 2);
    endproperty
    a_en: assert property (p_en) else $error("phase enable not taken");
    property p_off;
        wr_strobe_i && wr_addr_i == 8'h1B
        |-> ##2 phase_offset_word_o[7:0] == $past(wr_data_i, 2);
    endproperty
    a_off: assert property (p_off) else $error("phase offset low byte wrong");
    property p_adv;
        phase_advance_pulse_o
        |-> phase_shift_enable_o && $past(wr_strobe_i) && $past(wr_addr_i) == 8'h1D;
    endproperty
    a_adv: assert property (p_adv) else $error("advance pulse without cause");
    property p_pump;
        wr_strobe_i && wr_addr_i == 8'h1E
        |-> ##2 pump_current_code_o == $past(wr_data_i[7:4], 2);
    endproperty
    a_pump: assert property (p_pump) else $error("pump code not taken");
    property p_pcfg;
        wr_strobe_i && wr_addr_i == 8'h1E
        |-> ##2 pump_config_low_o == $past(wr_data_i[3:0], 2);
    endproperty
    a_pcfg: assert property (p_pcfg) else $error("pump low nibble not taken");
    property p_prst;
        $past(reset_i) |-> pump_current_code_o == 4'h4 && pump_config_low_o == 4'h8;
    endproperty
    a_prst: assert property (p_prst) else $error("pump register reset wrong");
    property p_mrst;
        $past(reset_i) |-> auxiliary_modulus_word_o == 14'h03E8;
    endproperty
    a_mrst: assert property (p_mrst) else $error("modulus reset wrong");
endmodule // synth_fraction_phase_regs_chk

bind synth_fraction_phase_regs synth_fraction_phase_regs_chk i_synth_fraction_phase_regs_chk (.*);

// ### sim/synth_fraction_phase_regs_test.sv
/* Self-checking bench for the fraction and phase register slice.
   Assumes divider words commit on a write to the integer low byte. */
`timescale 1ns/1ps
module synth_fraction_phase_regs_test;
    logic        sys_clk_i = 0;
    logic        reset_i = 1;
    logic        wr_strobe_i = 0;
    logic [7:0]  wr_addr_i = 8'h00;
    logic [7:0]  wr_data_i = 8'h00;
    logic [7:0]  rd_addr_i = 8'h00;
    logic [7:0]  rd_data_o;
    logic        rd_hit_o;
    logic [8:0]  primary_fraction_top_o;
    logic [13:0] auxiliary_fraction_word_o;
    logic [13:0] auxiliary_modulus_word_o;
    logic        phase_shift_enable_o;
    logic [23:0] phase_offset_word_o;
    logic        phase_advance_pulse_o;
    logic [3:0]  pump_current_code_o;
    logic [3:0]  pump_config_low_o;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [7:0]  wdat [9] = '{8'hA5, 8'h3B, 8'hFF, 8'h10, 8'hFF, 8'h12, 8'h34, 8'h56, 8'h9C};
    logic [7:0]  rexp [9] = '{8'hA5, 8'h3B, 8'h7F, 8'h10, 8'h7F, 8'h12, 8'h34, 8'h56, 8'h9C};
    logic [7:0]  rrst [9] = '{8'h00, 8'h00, 8'h00, 8'hE8, 8'h03, 8'h00, 8'h00, 8'h00, 8'h48};
    synth_fraction_phase_regs i_synth_fraction_phase_regs (.*);
    always #12.5 sys_clk_i = ~sys_clk_i;
    task conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // The run needs about 130 cycles; the ceiling leaves wide margin.
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp)
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        if (seen !== exp)
            error_cnt++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_strobe_i <= 1'b1;
        wr_addr_i <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_strobe_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_addr_i <= a;
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(rd_data_o, e);
        chk(rd_hit_o, a >= 8'h16 && a <= 8'h1E);
    endtask
    task automatic rst_chk;
        for (int i = 0; i < 9; i++)
            rd(8'h16 + i, rrst[i]);
        chk(auxiliary_modulus_word_o, 14'h03E8);
        chk(pump_config_low_o, 4'h8);
        chk(pump_current_code_o, 4'h4);
        chk(primary_fraction_top_o, 9'h000);
        chk(auxiliary_fraction_word_o, 14'h0000);
        chk(phase_shift_enable_o, 1'b0);
        chk(phase_offset_word_o, 24'h000000);
        chk(phase_advance_pulse_o, 1'b0);
        $display("test reset values done");
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rst_chk();
        for (int i = 0; i < 9; i++)
            wr(8'h16 + i, wdat[i]);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 9; i++)
            rd(8'h16 + i, rexp[i]);
        chk(auxiliary_modulus_word_o, 14'h03E8);
        chk(primary_fraction_top_o, 9'h000);
        $display("test register table done");
        wr(8'h10, 8'h32);
        chk(primary_fraction_top_o, 9'h1A5);
        chk(auxiliary_fraction_word_o, 14'h3F9D);
        chk(auxiliary_modulus_word_o, 14'h3F10);
        chk(phase_shift_enable_o, 1'b1);
        chk(phase_offset_word_o, 24'h563412);
        chk(pump_current_code_o, 4'h9);
        chk(pump_config_low_o, 4'hC);
        $display("test commit done");
        wr(8'h1D, 8'h56);
        chk(phase_advance_pulse_o, 1'b1);
        @(posedge sys_clk_i);
        #1;
        chk(phase_advance_pulse_o, 1'b0);
        wr(8'h1A, 8'h03);
        wr(8'h1B, 8'h00);
        wr(8'h1C, 8'h00);
        wr(8'h1D, 8'h00);
        chk(phase_advance_pulse_o, 1'b0);
        chk(phase_shift_enable_o, 1'b0);
        @(posedge sys_clk_i);
        #1;
        chk(phase_offset_word_o, 24'h000000);
        $display("test phase advance done");
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rst_chk();
        conclude();
    end
endmodule // synth_fraction_phase_regs_test
